// file: include/rpx_defs.vh
// Constants for the power-control and extended-RAM block of the RTC.
// Assumes a 200 MHz core clock; included by bare name from src/.
`ifndef RPX_DEFS_VH
`define RPX_DEFS_VH
// ==========================================================================
// Register offsets (bank 1)
`define RPX_OFS_STAT 8'h4A
`define RPX_OFS_ENAB 8'h4B
`define RPX_OFS_ADRL 8'h50
`define RPX_OFS_ADRH 8'h51
`define RPX_OFS_DATA 8'h53
// ==========================================================================
// Status register bit positions
`define RPX_ST_AUXV 7
`define RPX_ST_UIP 6
`define RPX_ST_BURST 5
`define RPX_ST_PREL 3
`define RPX_ST_RCF 2
`define RPX_ST_WF 1
`define RPX_ST_KF 0
// Enable register bit positions
`define RPX_EN_ABE 7
`define RPX_EN_RAW_OSC_OUTPUT_ENABLE 6
`define RPX_EN_XSEL 5
`define RPX_EN_RCE 4
`define RPX_EN_PRS 3
`define RPX_EN_RIE 2
`define RPX_EN_WIE 1
`define RPX_EN_KSE 0
// Reset values
`define RPX_STAT_RST 8'h00
`define RPX_ENAB_RST 8'h40
// ==========================================================================
// Timing: clock rate, kickstart width (ns), timeout (s), recovery (ns)
`define RPX_CLK_HZ 200000000
`define RPX_KS_MIN_NS 2000
`define RPX_KS_MIN_CYC ((`RPX_KS_MIN_NS * 200 + 999) / 1000)
`define RPX_POTO_S 2
`define RPX_POTO_CYC (`RPX_POTO_S * `RPX_CLK_HZ)
`define RPX_REC_NS 1000
`define RPX_REC_CYC ((`RPX_REC_NS * 200 + 999) / 1000)
`define RPX_UIP_LEAD_US 122
`define RPX_UIP_LEAD_CYC (`RPX_UIP_LEAD_US * 200)
`define RPX_USER_RAM 114
`endif

// file: src/rpx_power_extram.v
// Wake-up/kickstart power control, user-RAM clear and extended RAM access.
// Assumes host strobes synchronous to clk_i and one-cycle strobe pulses.
`timescale 1ns/1ps
`include "rpx_defs.vh"

module rpx_power_extram #(
   parameter AW = 13,                       // Extended RAM address width
   parameter POTO_CYC = `RPX_POTO_CYC,      // Power-on timeout cycles
   parameter UIP_LEAD_CYC = `RPX_UIP_LEAD_CYC // Update-flag lead cycles
) (
   input wire clk_i,                 // 200 MHz clock
   input wire reset_n_i,             // Async reset, active low
   input wire bus_cs_i,              // Chip select qualifies strobes
   input wire bus_bank1_i,           // Bank select bit of control A
   input wire [7:0] bus_addr_i,      // Latched register address
   input wire bus_wr_i,              // Write strobe rising edge pulse
   input wire bus_rd_i,              // Read strobe rising edge pulse
   input wire [7:0] bus_wdata_i,     // Write data
   output reg [7:0] bus_rdata_o,     // Read data
   output reg bus_rvalid_o,          // Read data valid pulse
   input wire osc_clk_i,             // Raw 32.768 kHz oscillator level
   input wire [2:0] divider_ctrl_i,  // Divider control bits of register A
   input wire main_power_i,          // Main supply present
   input wire aux_battery_valid_i,   // Auxiliary battery good
   input wire alarm_match_i,         // Date/time alarm match pulse
   input wire update_start_i,        // Pulse: update cycle begins in lead time
   input wire update_end_i,          // Pulse: update cycle ends
   input wire other_irq_i,           // Other pending interrupt sources
   input wire kickstart_in_n_i,      // Kickstart input
   input wire ram_clear_in_n_i,      // RAM clear input
   output reg power_request_n_o,     // Power request pin level
   output reg power_request_oe_o,    // Power request drive enable
   output reg irq_n_o,               // Interrupt pin level
   output reg irq_oe_o,              // Interrupt drive enable
   output reg square_wave_out_o,     // Raw oscillator output
   output reg xtal_load_sel_o,       // 0 = 6 pF, 1 = 12.5 pF
   output reg user_ram_fill_o,       // Pulse: fill user RAM with ones
   output reg [AW-1:0] xram_addr_o,  // Extended RAM address
   output reg xram_we_o,             // Extended RAM write pulse
   output reg [7:0] xram_wdata_o,    // Extended RAM write data
   input wire [7:0] xram_rdata_i     // Extended RAM read data
);

   // ========================================================================
   // Register state
   reg [7:0] enab_q;
   reg burst_q, prel_q, rcf_q, wf_q, kf_q, uip_q;
   reg [15:0] adr_q;
   reg [15:0] ks_cnt_q;
   reg ks_seen_q, ks_prev_q, rc_prev_q, main_prev_q;
   reg [15:0] rec_cnt_q;
   reg [31:0] poto_cnt_q;
   reg poto_act_q;
   reg [31:0] uip_cnt_q;
   reg uip_arm_q;
   reg rd_pend_q;
   // Recovery count held at the counter's own width
   localparam [15:0] REC_CYC = `RPX_REC_CYC;

   // Address decode helper, used for reads and writes
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // Accesses are dropped while the clear recovery window runs
   wire locked = (rec_cnt_q != 16'h0000);
   wire acc_ok = bus_cs_i && bus_bank1_i && !locked;
   wire wr_ev = acc_ok && bus_wr_i;
   wire rd_ev = acc_ok && bus_rd_i;

   // Divider pattern 01X means oscillator on and chain running
   wire chain_run = (divider_ctrl_i[2:1] == 2'b01);
   wire wake_pend = wf_q && enab_q[`RPX_EN_WIE];
   wire kick_pend = kf_q && enab_q[`RPX_EN_KSE];
   wire rc_pend = rcf_q && enab_q[`RPX_EN_RIE];
   wire battery_ok = enab_q[`RPX_EN_ABE] && chain_run;

   // ========================================================================
   // Kickstart low-pulse qualifier: width counted, flag set once per pulse
   wire ks_fire = !kickstart_in_n_i && !ks_seen_q &&
                  (ks_cnt_q >= `RPX_KS_MIN_CYC - 1);
   wire alarm_fire = alarm_match_i && (main_power_i || battery_ok);
   // RAM clear edge only acts when enabled
   wire rc_fall = rc_prev_q && !ram_clear_in_n_i;
   wire rc_fire = rc_fall && enab_q[`RPX_EN_RCE];

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ks_cnt_q <= 16'h0000;
         ks_seen_q <= 1'b0;
         ks_prev_q <= 1'b1;
         rc_prev_q <= 1'b1;
         main_prev_q <= 1'b0;
      end else begin
         ks_prev_q <= kickstart_in_n_i;
         rc_prev_q <= ram_clear_in_n_i;
         main_prev_q <= main_power_i;
         if (kickstart_in_n_i) begin
            ks_cnt_q <= 16'h0000;
            ks_seen_q <= 1'b0;
         end else begin
            if (ks_cnt_q != 16'hFFFF)
               ks_cnt_q <= ks_cnt_q + 16'h0001;
            if (ks_fire)
               ks_seen_q <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Status flags: hardware set wins over a software clear
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         burst_q <= 1'b0;
         prel_q <= 1'b0;
         rcf_q <= 1'b0;
         wf_q <= 1'b0;
         kf_q <= 1'b0;
         enab_q <= `RPX_ENAB_RST;
      end else begin
         if (wr_ev && hit(bus_addr_i, `RPX_OFS_STAT)) begin
            burst_q <= bus_wdata_i[`RPX_ST_BURST];
            prel_q <= bus_wdata_i[`RPX_ST_PREL];
            rcf_q <= bus_wdata_i[`RPX_ST_RCF];
            wf_q <= bus_wdata_i[`RPX_ST_WF];
            kf_q <= bus_wdata_i[`RPX_ST_KF];
         end
         if (wr_ev && hit(bus_addr_i, `RPX_OFS_ENAB))
            enab_q <= bus_wdata_i;
         if (alarm_fire)
            wf_q <= 1'b1;
         if (ks_fire)
            kf_q <= 1'b1;
         if (rc_fire)
            rcf_q <= 1'b1;
         // Enabled pending wake or kickstart event pulls the release bit back to zero
         if (wake_pend || kick_pend)
            prel_q <= 1'b0;
         // Raw clock output re-enabled whenever main supply returns
         if (main_power_i && !main_prev_q)
            enab_q[`RPX_EN_RAW_OSC_OUTPUT_ENABLE] <= 1'b1;
      end
   end

   // ========================================================================
   // Power-on timeout: without main supply the event-driven request is dropped after 2 s
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         poto_cnt_q <= 32'h0000_0000;
         poto_act_q <= 1'b0;
      end else if (main_power_i || !(wake_pend || kick_pend)) begin
         poto_cnt_q <= 32'h0000_0000;
         poto_act_q <= 1'b0;
      end else if (!poto_act_q && chain_run) begin
         poto_act_q <= 1'b1;
         poto_cnt_q <= 32'h0000_0000;
      end else if (poto_act_q && chain_run && poto_cnt_q < POTO_CYC) begin
         poto_cnt_q <= poto_cnt_q + 32'h0000_0001;
      end
   end
   wire poto_expired = poto_act_q && (poto_cnt_q >= POTO_CYC);

   // ========================================================================
   // Update-in-progress flag: set lead time ahead, cleared at update end
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         uip_q <= 1'b0;
         uip_arm_q <= 1'b0;
         uip_cnt_q <= 32'h0000_0000;
      end else begin
         if (update_start_i) begin
            uip_q <= 1'b1;
            uip_arm_q <= 1'b1;
            uip_cnt_q <= 32'h0000_0000;
         end else if (uip_arm_q && uip_cnt_q < UIP_LEAD_CYC)
            uip_cnt_q <= uip_cnt_q + 32'h0000_0001;
         if (update_end_i) begin
            uip_q <= 1'b0;
            uip_arm_q <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Recovery lockout after a clear input activation
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rec_cnt_q <= 16'h0000;
      else if (rc_fire)
         rec_cnt_q <= REC_CYC;
      else if (locked)
         rec_cnt_q <= rec_cnt_q - 16'h0001;
   end

   // ========================================================================
   // Extended RAM address, data port and burst increment
   wire [15:0] adr_mask = (16'h0001 << AW) - 16'h0001;
   wire data_hit = hit(bus_addr_i, `RPX_OFS_DATA);
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         adr_q <= 16'h0000;
         xram_we_o <= 1'b0;
         xram_wdata_o <= 8'h00;
      end else begin
         xram_we_o <= wr_ev && data_hit;
         if (wr_ev && data_hit)
            xram_wdata_o <= bus_wdata_i;
         if (wr_ev && hit(bus_addr_i, `RPX_OFS_ADRL))
            adr_q[7:0] <= bus_wdata_i;
         else if (wr_ev && hit(bus_addr_i, `RPX_OFS_ADRH))
            adr_q[15:8] <= bus_wdata_i;
         else if ((wr_ev || rd_ev) && data_hit && burst_q)
            adr_q <= (adr_q + 16'h0001) & adr_mask;
         // Burst off: address left as written
      end
   end

   // ========================================================================
   // Read path; reserved bits return zero
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_rdata_o <= 8'h00;
         bus_rvalid_o <= 1'b0;
      end else begin
         bus_rvalid_o <= rd_ev;
         if (rd_ev) begin
            if (hit(bus_addr_i, `RPX_OFS_STAT))
               bus_rdata_o <= {aux_battery_valid_i, uip_q, burst_q, 1'b0,
                               prel_q, rcf_q, wf_q, kf_q};
            else if (hit(bus_addr_i, `RPX_OFS_ENAB))
               bus_rdata_o <= enab_q;
            else if (hit(bus_addr_i, `RPX_OFS_ADRL))
               bus_rdata_o <= adr_q[7:0];
            else if (hit(bus_addr_i, `RPX_OFS_ADRH))
               bus_rdata_o <= adr_q[15:8];
            else if (data_hit)
               bus_rdata_o <= xram_rdata_i;
            else
               bus_rdata_o <= 8'h00;
         end
      end
   end

   // ========================================================================
   // Pin drive: power request, interrupt, square wave, crystal select
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         power_request_n_o <= 1'b0;
         power_request_oe_o <= 1'b0;
         irq_n_o <= 1'b0;
         irq_oe_o <= 1'b0;
         square_wave_out_o <= 1'b0;
         xtal_load_sel_o <= 1'b0;
         user_ram_fill_o <= 1'b0;
         xram_addr_o <= {AW{1'b0}};
      end else begin
         power_request_n_o <= 1'b0;
         if (main_power_i)
            // Powered: release bit clear or a pending wake/kickstart event drives it; events clear the bit
            power_request_oe_o <= !prel_q || wake_pend || kick_pend;
         else
            // Power fail: select bit keeps the request for the whole outage,
            // battery-mode events add to it and need the chain running
            power_request_oe_o <= (enab_q[`RPX_EN_PRS] && !prel_q) ||
                                  (battery_ok && (wake_pend || kick_pend)
                                   && !poto_expired);
         // Interrupt floats without main supply
         irq_n_o <= 1'b0;
         irq_oe_o <= main_power_i &&
                     (wake_pend || kick_pend || rc_pend || other_irq_i);
         square_wave_out_o <= enab_q[`RPX_EN_RAW_OSC_OUTPUT_ENABLE] && osc_clk_i;
         xtal_load_sel_o <= enab_q[`RPX_EN_XSEL];
         user_ram_fill_o <= rc_fire;
         xram_addr_o <= adr_q[AW-1:0];
      end
   end

endmodule // rpx_power_extram

// file: tb/rpx_power_extram_properties.sv
// Concurrent checks on the ports of the power-control and extended-RAM block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module rpx_power_extram_properties #(
   parameter AW = 13 // RAM address width
) (
   input wire clk_i, // Clock
   input wire reset_n_i, // Reset
   input wire bus_cs_i, // Select
   input wire bus_bank1_i, // Bank
   input wire [7:0] bus_addr_i, // Address
   input wire bus_wr_i, // Write
   input wire bus_rd_i, // Read
   input wire [7:0] bus_wdata_i, // Write data
   input wire [7:0] bus_rdata_o, // Read data
   input wire bus_rvalid_o, // Read valid
   input wire osc_clk_i, // Oscillator
   input wire main_power_i, // Supply
   input wire other_irq_i, // Other sources
   input wire ram_clear_in_n_i, // Clear pin
   input wire power_request_n_o, // Power pin level
   input wire irq_n_o, // Irq pin level
   input wire irq_oe_o, // Irq enable
   input wire square_wave_out_o, // Raw clock
   input wire user_ram_fill_o, // Fill pulse
   input wire [AW-1:0] xram_addr_o, // RAM address
   input wire xram_we_o, // RAM write
   input wire [7:0] xram_wdata_o, // RAM data
   input wire [7:0] xram_rdata_i // RAM read data
);
   // ======================================================================
   // Helper logic
   // Cycles since a clear-pin fall; gates the data-port write check past the lockout
   reg [7:0] clr_age_q;
   reg clr_prev_q;
   wire [7:0] clr_age_d;
   wire xa_w;
   assign clr_age_d = (clr_prev_q & !ram_clear_in_n_i) ? 8'h00 :
                      (clr_age_q == 8'hFF) ? 8'hFF : clr_age_q + 8'h01;
   assign xa_w = bus_cs_i & bus_bank1_i & (bus_wr_i | bus_rd_i) &
                 (bus_addr_i == 8'h50 | bus_addr_i == 8'h51 | bus_addr_i == 8'h53);
   // Age counter starts saturated so the first accesses are checked
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clr_age_q <= 8'hFF;
         clr_prev_q <= 1'b1;
      end else begin
         clr_age_q <= clr_age_d;
         clr_prev_q <= ram_clear_in_n_i;
      end
   end
   // ======================================================================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_data_wr;
      bus_wr_i && bus_cs_i && bus_bank1_i && bus_addr_i == 8'h53 && clr_age_q >= 8'hD2;
   endsequence
   rvalid_cause_a: assert property (bus_rvalid_o |-> $past(bus_rd_i & bus_cs_i & bus_bank1_i))
      else $error("read valid without a read");
   data_write_a: assert property (s_data_wr |=> xram_we_o && xram_wdata_o == $past(bus_wdata_i))
      else $error("data port write lost");
   we_cause_a: assert property (xram_we_o |-> $past(bus_wr_i && bus_addr_i == 8'h53))
      else $error("RAM write without data port write");
   data_read_a: assert property (bus_rvalid_o && $past(bus_addr_i) == 8'h53 |->
      bus_rdata_o == $past(xram_rdata_i)) else $error("data port read wrong");
   addr_cause_a: assert property ($changed(xram_addr_o) |-> $past(xa_w) || $past(xa_w, 2))
      else $error("RAM address moved without access");
   sqw_follow_a: assert property (square_wave_out_o |-> $past(osc_clk_i))
      else $error("raw clock output not oscillator");
   fill_pulse_a: assert property (user_ram_fill_o |=> !user_ram_fill_o)
      else $error("fill pulse too long");
   irq_pending_a: assert property ($past(other_irq_i && main_power_i) |-> irq_oe_o)
      else $error("interrupt dropped while other source pends");
   drain_low_a: assert property (!power_request_n_o && !irq_n_o)
      else $error("open-drain pin driven high");
   reserved_zero_a: assert property (bus_rvalid_o && $past(bus_addr_i) == 8'h4A |->
      !bus_rdata_o[4]) else $error("reserved status bit reads one");
endmodule // rpx_power_extram_properties

bind rpx_power_extram rpx_power_extram_properties #(.AW(AW)) u_props (.clk_i, .reset_n_i,
   .bus_cs_i, .bus_bank1_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o,
   .bus_rvalid_o, .osc_clk_i, .main_power_i, .other_irq_i, .ram_clear_in_n_i,
   .power_request_n_o, .irq_n_o, .irq_oe_o, .square_wave_out_o, .user_ram_fill_o,
   .xram_addr_o, .xram_we_o, .xram_wdata_o, .xram_rdata_i);

// file: tb/rpx_xram_model.sv
// Behavioural extended-RAM array standing behind the block.
// Assumes the write pulse and address come from the block on clk_i.
`timescale 1ns/1ps
module rpx_xram_model #(
   parameter AW = 13 // Address width
) (
   input wire clk_i, // Clock
   input wire [AW-1:0] addr_i, // Address
   input wire we_i, // Write pulse
   input wire [7:0] wdata_i, // Write data
   output wire [7:0] rdata_o // Read data
);
   // ======================================================================
   // Array: no reset, unwritten cells read unknown like real cells
   reg [7:0] mem [0:(1<<AW)-1];
   always @(posedge clk_i) begin
      if (we_i) mem[addr_i] <= wdata_i;
   end
   assign rdata_o = mem[addr_i];
endmodule // rpx_xram_model

// file: tb/tb_rpx_power_extram.sv
// Self-checking bench for the power-control and extended-RAM block.
// Assumes the checker is bound in and the RAM model sits on the RAM port.
`timescale 1ns/1ps
module tb_rpx_power_extram;
   // ======================================================================
   // Signals
   logic clk_i = 0, reset_n_i = 0, bus_cs_i = 1, bus_bank1_i = 1, bus_wr_i = 0, bus_rd_i = 0;
   logic osc_clk_i = 0, main_power_i = 1, aux_battery_valid_i = 1, alarm_match_i = 0;
   logic update_start_i = 0, update_end_i = 0, other_irq_i = 0, kickstart_in_n_i = 1;
   logic ram_clear_in_n_i = 1, bus_rvalid_o, power_request_n_o, power_request_oe_o;
   logic irq_n_o, irq_oe_o, square_wave_out_o, xtal_load_sel_o, user_ram_fill_o, xram_we_o;
   logic [7:0] bus_addr_i = 8'h00, bus_wdata_i = 8'h00, bus_rdata_o, xram_wdata_o, xram_rdata_i;
   logic [7:0] i;
   logic [2:0] divider_ctrl_i = 3'b010;
   logic [12:0] xram_addr_o;
   int err_count = 0, n_compared = 0, fills = 0;
   // Short timeout so the power-fail window is reachable in a short run
   rpx_power_extram #(.AW(13), .POTO_CYC(50), .UIP_LEAD_CYC(10)) u_dut (.clk_i, .reset_n_i,
      .bus_cs_i, .bus_bank1_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o,
      .bus_rvalid_o, .osc_clk_i, .divider_ctrl_i, .main_power_i, .aux_battery_valid_i,
      .alarm_match_i, .update_start_i, .update_end_i, .other_irq_i, .kickstart_in_n_i,
      .ram_clear_in_n_i, .power_request_n_o, .power_request_oe_o, .irq_n_o, .irq_oe_o,
      .square_wave_out_o, .xtal_load_sel_o, .user_ram_fill_o, .xram_addr_o, .xram_we_o,
      .xram_wdata_o, .xram_rdata_i);
   rpx_xram_model #(.AW(13)) u_ram (.clk_i, .addr_i(xram_addr_o), .we_i(xram_we_o),
      .wdata_i(xram_wdata_o), .rdata_o(xram_rdata_i));
   // ======================================================================
   // Clocks, slow oscillator stand-in and fill-pulse counter
   initial forever #2.5 clk_i = ~clk_i;
   always begin
      repeat (7) @(posedge clk_i);
      #1 osc_clk_i = ~osc_clk_i;
   end
   always @(posedge clk_i) begin
      if (user_ram_fill_o === 1'b1) fills++;
   end
   // ======================================================================
   // Tasks
   task summarize;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input [12:0] e, input [12:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_i);
      #1 bus_addr_i = a;
      bus_wdata_i = d;
      bus_wr_i = 1;
      cyc(1);
      bus_wr_i = 0;
   endtask
   // Read answer is registered: valid in the cycle after the strobe
   task rd(input [7:0] a, input [7:0] e, input bit v = 1);
      @(posedge clk_i);
      #1 bus_addr_i = a;
      bus_rd_i = 1;
      cyc(1);
      bus_rd_i = 0;
      chk("rvalid", {12'h000, v}, {12'h000, bus_rvalid_o});
      if (v) chk({"reg ", $sformatf("%h", a)}, {5'h00, e}, {5'h00, bus_rdata_o});
   endtask
   task kick(input int n);
      kickstart_in_n_i = 0;
      cyc(n);
      kickstart_in_n_i = 1;
      cyc(2);
   endtask
   // ======================================================================
   // Sequence
   initial begin
      #100000;
      err_count++;
      summarize();
   end
   initial begin
      cyc(2);
      reset_n_i = 1;
      rd(8'h4A, 8'h80);
      rd(8'h4B, 8'h40);
      wr(8'h4A, 8'h17);
      rd(8'h4A, 8'h87);
      chk("irq masked", 0, irq_oe_o);
      wr(8'h4B, 8'h43);
      cyc(2);
      chk("irq on", 1, irq_oe_o);
      other_irq_i = 1;
      wr(8'h4A, 8'h00);
      cyc(2);
      chk("irq other", 1, irq_oe_o);
      other_irq_i = 0;
      cyc(2);
      chk("irq off", 0, irq_oe_o);
      wr(8'h4A, 8'h08);
      cyc(2);
      chk("pwr float", 0, power_request_oe_o);
      alarm_match_i = 1;
      cyc(1);
      alarm_match_i = 0;
      cyc(2);
      chk("pwr wake", 1, power_request_oe_o);
      chk("irq wake", 1, irq_oe_o);
      rd(8'h4A, 8'h82);
      wr(8'h4A, 8'h00);
      wr(8'h4B, 8'h41);
      kick(300);
      rd(8'h4A, 8'h80);
      kick(420);
      rd(8'h4A, 8'h81);
      chk("irq kick", 1, irq_oe_o);
      wr(8'h4A, 8'h00);
      wr(8'h50, 8'h34);
      wr(8'h51, 8'h12);
      wr(8'h53, 8'hA5);
      wr(8'h53, 8'h5A);
      cyc(2);
      chk("xaddr", 13'h1234, xram_addr_o);
      rd(8'h53, 8'h5A);
      wr(8'h4A, 8'h20);
      wr(8'h50, 8'hFE);
      wr(8'h51, 8'h1F);
      for (i = 0; i < 3; i++) wr(8'h53, 8'hC0 + i);
      cyc(2);
      chk("wrap", 13'h0001, xram_addr_o);
      wr(8'h50, 8'hFE);
      wr(8'h51, 8'h1F);
      for (i = 0; i < 3; i++) rd(8'h53, 8'hC0 + i);
      wr(8'h4A, 8'h00);
      wr(8'h4B, 8'h54);
      ram_clear_in_n_i = 0;
      cyc(4);
      rd(8'h4A, 8'h00, 0);
      ram_clear_in_n_i = 1;
      cyc(220);
      rd(8'h4A, 8'h84);
      chk("irq clear", 1, irq_oe_o);
      chk("fill", 1, fills);
      wr(8'h4A, 8'h00);
      wr(8'h4B, 8'h40);
      ram_clear_in_n_i = 0;
      cyc(4);
      ram_clear_in_n_i = 1;
      rd(8'h4A, 8'h80);
      chk("no fill", 1, fills);
      update_start_i = 1;
      cyc(1);
      update_start_i = 0;
      rd(8'h4A, 8'hC0);
      update_end_i = 1;
      cyc(1);
      update_end_i = 0;
      rd(8'h4A, 8'h80);
      wr(8'h4B, 8'h28);
      cyc(2);
      chk("xtal", 1, xtal_load_sel_o);
      main_power_i = 0;
      cyc(3);
      chk("fail keep", 1, power_request_oe_o);
      main_power_i = 1;
      cyc(4);
      wr(8'h4B, 8'h00);
      main_power_i = 0;
      cyc(3);
      chk("fail float", 0, power_request_oe_o);
      main_power_i = 1;
      cyc(4);
      rd(8'h4B, 8'h40);
      summarize();
   end
endmodule // tb_rpx_power_extram
